/* File: ebc_pkg.sv */
// Package for the external bus control-signal block.
// Assumes one 100 MHz system clock and a synchronous active-high reset.
package ebc_pkg;

  // ----------------------------------------------------------------
  // Access spaces and requests
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBC_SP_PROG = 2'h0,
    EBC_SP_DATA = 2'h1,
    EBC_SP_IO   = 2'h2
  } ebc_space_e;

  localparam int EBC_WS_W = 3;
  localparam logic [EBC_WS_W-1:0] EBC_READY_MIN_WS = 3'h2;
  localparam logic [EBC_WS_W-1:0] EBC_WS_ZERO = 3'h0;

  typedef struct packed {
    logic                valid;
    ebc_space_e          space;
    logic                write;
    logic                dma;
    logic [EBC_WS_W-1:0] wait_states;
  } ebc_req_s;

  // ----------------------------------------------------------------
  // Pin bundle: output values and output enables (enable low = drive)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic prog_sel_n;
    logic data_sel_n;
    logic io_sel_n;
    logic mem_strobe_n;
    logic io_strobe_n;
    logic rd_wr_n;
    logic ready;
  } ebc_pins_s;

  localparam ebc_pins_s EBC_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam ebc_pins_s EBC_OE_ALL_OFF = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  localparam logic EBC_MODE_HOST = 1'b0;
  localparam logic EBC_MODE_EXTERNAL_MEMORY_INTERFACE = 1'b1;

  // ----------------------------------------------------------------
  // Bus cycle states (Gray along idle -> strobe -> end)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBC_ST_IDLE   = 2'h0,
    EBC_ST_STROBE = 2'h1,
    EBC_ST_END    = 2'h3
  } ebc_state_e;

endpackage

/* File: ebc_sync2.sv */
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to i_sys_clk.
`timescale 1ns/1ns
module ebc_sync2
  import ebc_pkg::*;
(
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  // Level
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

/* File: ebc_ctrl.sv */
// External bus control-signal logic: space selects, strobes, R/W, ready.
// Assumes requests come from core logic on i_sys_clk; pins are asynchronous.
//
// Operation
// [RULE_01] Program select low for whole program access
// [RULE_02] Data select low during data access
// [RULE_03] I/O select low during I/O access
// [RULE_04] Output-off low floats all control outputs
// [RULE_05] Memory strobe only for program/data, memory mode
// [RULE_06] Ready low adds one cycle, resample
// [RULE_07] Ready used only with two+ wait states
// [RULE_08] External device drives ready high when done
// [RULE_09] Read/write high except during writes
// [RULE_10] I/O strobe only for processor I/O access
// [RULE_11] Host mode: selects become host data strobes
// [RULE_12] Host mode: ready pin outputs host ready
// [RULE_13] Host mode: read/write pin becomes input
// [RULE_14] Host mode: I/O select is subsystem SUBSYS_B_GPIO_LINE3
// [RULE_15] Host mode: I/O strobe is subsystem SUBSYS_A_GPIO_LINE3
// [RULE_16] Mode input 0 host, 1 memory interface
// [RULE_17] Selects, strobes active low, high between accesses
`timescale 1ns/1ns
module ebc_ctrl
  import ebc_pkg::*;
(
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  // Mode and output-off pins
  input  wire logic i_interface_mode_select,
  input  wire logic i_output_off_n,
  // Core access request
  input  wire ebc_req_s i_req,
  output logic o_req_ready,
  output logic o_done,
  // Host port side
  input  wire logic i_host_port_ready,
  output logic o_host_data_strobe_1_n,
  output logic o_host_data_strobe_2_n,
  output logic o_host_rd_wr_n,
  // Subsystem GPIO line 3 (A and B)
  input  wire logic i_subsys_a_gpio_line3_out,
  input  wire logic i_subsys_a_gpio_line3_dir,
  input  wire logic i_subsys_a_timer_en,
  input  wire logic i_subsys_a_timer_out,
  output logic o_subsys_a_gpio_line3_in,
  input  wire logic i_subsys_b_gpio_line3_out,
  input  wire logic i_subsys_b_gpio_line3_dir,
  input  wire logic i_subsys_b_timer_en,
  input  wire logic i_subsys_b_timer_out,
  output logic o_subsys_b_gpio_line3_in,
  // Pins: input, output, output enable (low = drive)
  input  wire ebc_pins_s i_pins,
  output ebc_pins_s o_pins,
  output ebc_pins_s o_pins_oe
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pin_raw;
  logic [6:0] pin_sync;
  logic mode_sync;
  logic off_n_sync;

  assign pin_raw = {i_pins.prog_sel_n, i_pins.data_sel_n, i_pins.io_sel_n,
                    i_pins.io_strobe_n, i_pins.rd_wr_n, i_pins.ready,
                    i_interface_mode_select};

  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : g_sync
      ebc_sync2 u_sync (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (pin_raw[g]),
        .o_sync    (pin_sync[g])
      );
    end
  endgenerate

  ebc_sync2 u_off_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_output_off_n),
    .o_sync    (off_n_sync)
  );

  assign mode_sync = pin_sync[0];

  logic external_memory_interface_mode;
  assign external_memory_interface_mode = (mode_sync == EBC_MODE_EXTERNAL_MEMORY_INTERFACE); // RULE_16

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  ebc_state_e state_r;
  ebc_state_e state_nxt;
  ebc_req_s cur_r;
  logic [EBC_WS_W-1:0] ws_cnt_r;
  logic use_ready;
  logic ready_ok;

  assign use_ready = (cur_r.wait_states >= EBC_READY_MIN_WS); // RULE_07
  assign ready_ok = !use_ready || pin_sync[1]; // RULE_06 RULE_08

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      EBC_ST_IDLE:
        if (i_req.valid && external_memory_interface_mode)
          state_nxt = EBC_ST_STROBE;
      EBC_ST_STROBE:
        if (ws_cnt_r == EBC_WS_ZERO && ready_ok)
          state_nxt = EBC_ST_END; // RULE_06
      EBC_ST_END:
        state_nxt = EBC_ST_IDLE; // RULE_17
      default:
        state_nxt = EBC_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      state_r <= EBC_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      cur_r <= '0;
      ws_cnt_r <= EBC_WS_ZERO;
    end
    else if (state_r == EBC_ST_IDLE && state_nxt == EBC_ST_STROBE)
    begin
      cur_r <= i_req;
      ws_cnt_r <= i_req.wait_states;
    end
    else if (state_r == EBC_ST_STROBE && ws_cnt_r != EBC_WS_ZERO)
      ws_cnt_r <= ws_cnt_r - 3'h1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_req_ready <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_req_ready <= (state_nxt == EBC_ST_IDLE) && external_memory_interface_mode;
      o_done <= (state_r == EBC_ST_STROBE) && (state_nxt == EBC_ST_END);
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic act;
  ebc_pins_s pins_nxt;
  ebc_pins_s oe_nxt;

  assign act = (state_nxt == EBC_ST_STROBE);

  always_comb
  begin
    pins_nxt = EBC_PINS_IDLE;
    oe_nxt = EBC_OE_ALL_OFF;
    if (external_memory_interface_mode)
    begin
      oe_nxt = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      if (act || state_r == EBC_ST_STROBE)
      begin
        pins_nxt.prog_sel_n = !(cur_r.space == EBC_SP_PROG); // RULE_01 RULE_17
        pins_nxt.data_sel_n = !(cur_r.space == EBC_SP_DATA); // RULE_02
        pins_nxt.io_sel_n = !(cur_r.space == EBC_SP_IO); // RULE_03
        pins_nxt.rd_wr_n = !cur_r.write; // RULE_09
      end
      if (state_r == EBC_ST_STROBE)
      begin
        pins_nxt.mem_strobe_n = (cur_r.space == EBC_SP_IO); // RULE_05
        pins_nxt.io_strobe_n = !(cur_r.space == EBC_SP_IO && !cur_r.dma); // RULE_10
      end
      if (state_r == EBC_ST_IDLE && act)
      begin
        pins_nxt.prog_sel_n = !(i_req.space == EBC_SP_PROG);
        pins_nxt.data_sel_n = !(i_req.space == EBC_SP_DATA);
        pins_nxt.io_sel_n = !(i_req.space == EBC_SP_IO);
        pins_nxt.rd_wr_n = !i_req.write;
      end
    end
    else
    begin
      // Host mode: ready out driven, GPIO3 lines driven per direction or when the timer is enabled
      oe_nxt.ready = 1'b0; // RULE_12
      pins_nxt.ready = i_host_port_ready;
      pins_nxt.io_sel_n = i_subsys_b_timer_en ? i_subsys_b_timer_out
                                              : i_subsys_b_gpio_line3_out; // RULE_14
      oe_nxt.io_sel_n = !(i_subsys_b_timer_en || i_subsys_b_gpio_line3_dir);
      pins_nxt.io_strobe_n = i_subsys_a_timer_en ? i_subsys_a_timer_out
                                                 : i_subsys_a_gpio_line3_out; // RULE_15
      oe_nxt.io_strobe_n = !(i_subsys_a_timer_en || i_subsys_a_gpio_line3_dir);
    end
    if (!off_n_sync)
      oe_nxt = EBC_OE_ALL_OFF; // RULE_04
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_pins <= EBC_PINS_IDLE;
      o_pins_oe <= EBC_OE_ALL_OFF;
    end
    else
    begin
      o_pins <= pins_nxt;
      o_pins_oe <= oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Host-mode inputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_host_data_strobe_1_n <= 1'b1;
      o_host_data_strobe_2_n <= 1'b1;
      o_host_rd_wr_n <= 1'b1;
      o_subsys_a_gpio_line3_in <= 1'b0;
      o_subsys_b_gpio_line3_in <= 1'b0;
    end
    else
    begin
      o_host_data_strobe_1_n <= external_memory_interface_mode ? 1'b1 : pin_sync[6]; // RULE_11
      o_host_data_strobe_2_n <= external_memory_interface_mode ? 1'b1 : pin_sync[5]; // RULE_11
      o_host_rd_wr_n <= external_memory_interface_mode ? 1'b1 : pin_sync[2]; // RULE_13
      o_subsys_b_gpio_line3_in <= pin_sync[4];
      o_subsys_a_gpio_line3_in <= pin_sync[3];
    end
  end

endmodule

/* File: ebc_ctrl_asserts.sv */
// Port assertions for the external bus control block.
// Assumes binding to ebc_ctrl; one clock domain.
`timescale 1ns/1ns
module ebc_ctrl_asserts
  import ebc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Watched ports
  input wire logic i_output_off_n,
  input wire ebc_req_s i_req,
  input wire logic o_req_ready,
  input wire logic o_done,
  input wire ebc_pins_s o_pins,
  input wire ebc_pins_s o_pins_oe
);
  // ----------------------------------
  // Properties
  // ----------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic take;
  assign take = o_req_ready && i_req.valid;
  property p_off;
    !i_output_off_n [*4] |-> o_pins_oe == EBC_OE_ALL_OFF;
  endproperty
  property p_prog;
    take && i_req.space == EBC_SP_PROG |=> !o_pins.prog_sel_n;
  endproperty
  property p_data;
    take && i_req.space == EBC_SP_DATA |=> !o_pins.data_sel_n;
  endproperty
  property p_io;
    take && i_req.space == EBC_SP_IO |=> !o_pins.io_sel_n;
  endproperty
  property p_rw;
    take |=> o_pins.rd_wr_n == !$past(i_req.write);
  endproperty
  property p_dma;
    take && i_req.space == EBC_SP_IO && i_req.dma |=> o_pins.io_strobe_n [*3];
  endproperty
  property p_ws0;
    take && i_req.wait_states == EBC_WS_ZERO |-> ##[2:4] o_done;
  endproperty
  property p_idle;
    o_done |=> o_pins.prog_sel_n && o_pins.data_sel_n && o_pins.io_sel_n;
  endproperty
  a_off: assert property (p_off) else $error("pins not floated");
  a_prog: assert property (p_prog) else $error("program select missing");
  a_data: assert property (p_data) else $error("data select missing");
  a_io: assert property (p_io) else $error("io select missing");
  a_rw: assert property (p_rw) else $error("direction wrong");
  a_dma: assert property (p_dma) else $error("io strobe on dma");
  a_ws0: assert property (p_ws0) else $error("ready not ignored");
  a_idle: assert property (p_idle) else $error("select not released");
  c_wait: cover property (take && i_req.wait_states > EBC_READY_MIN_WS);
  c_done: cover property (o_done);
  c_off: cover property (!i_output_off_n [*4]);
endmodule
bind ebc_ctrl ebc_ctrl_asserts i_ebc_ctrl_asserts (.i_sys_clk, .i_sys_rst, .i_output_off_n,
  .i_req, .o_req_ready, .o_done, .o_pins, .o_pins_oe);

/* File: ebc_mem_model.sv */
// External memory model driving the ready pin.
// Assumes i_sel_n is low while any space select is active.
`timescale 1ns/1ns
module ebc_mem_model (
  // Clock
  input wire logic i_sys_clk,
  // Bus side
  input wire logic i_sel_n,
  input wire logic [3:0] i_stall,
  output logic o_ready
);
  // ----------------------------------
  // Stall counter
  // ----------------------------------
  logic [3:0] cnt_r = 4'h0;
  logic tog_r = 1'b0;
  always_ff @(posedge i_sys_clk)
  begin
    cnt_r <= (i_sel_n || cnt_r == 4'hF) ? 4'h0 : cnt_r + 4'h1;
    tog_r <= ~tog_r;
  end
  // Pin toggles when unselected so a stale level is never seen
  assign o_ready = i_sel_n ? tog_r : (cnt_r >= i_stall);
endmodule

/* File: tb.sv */
// Self-checking testbench for the external bus control block.
// Assumes ebc_mem_model answers ready; host-side pins are driven here.
`timescale 1ns/1ns
module tb;
  import ebc_pkg::*;
  // ----------------------------------
  // Signals and instances
  // ----------------------------------
  logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_interface_mode_select = 1'b1, i_output_off_n = 1'b1;
  logic i_host_port_ready = 1'b0, mrdy, o_req_ready, o_done, o_host_data_strobe_1_n;
  logic o_host_data_strobe_2_n, o_host_rd_wr_n, o_subsys_a_gpio_line3_in, o_subsys_b_gpio_line3_in;
  logic i_subsys_a_gpio_line3_out, i_subsys_a_gpio_line3_dir, i_subsys_a_timer_en, i_subsys_a_timer_out;
  logic i_subsys_b_gpio_line3_out, i_subsys_b_gpio_line3_dir, i_subsys_b_timer_en, i_subsys_b_timer_out;
  logic [7:0] gp = 8'h00;
  logic [3:0] stall = 4'h0;
  logic [31:0] seed = 32'hF674D5DE;
  ebc_req_s i_req = '0;
  ebc_pins_s i_pins, o_pins, o_pins_oe, ext = EBC_PINS_IDLE;
  int error_cnt = 0, cmp_count = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  assign {i_subsys_b_timer_out, i_subsys_b_timer_en, i_subsys_b_gpio_line3_dir,
    i_subsys_b_gpio_line3_out, i_subsys_a_timer_out, i_subsys_a_timer_en,
    i_subsys_a_gpio_line3_dir, i_subsys_a_gpio_line3_out} = gp;
  assign i_pins = ebc_pins_s'((o_pins & ~o_pins_oe) | ({ext[6:1], mrdy} & o_pins_oe));
  ebc_ctrl i_ebc_ctrl (.*);
  ebc_mem_model i_ebc_mem_model (.i_sys_clk,
    .i_sel_n(i_pins.prog_sel_n & i_pins.data_sel_n & i_pins.io_sel_n), .i_stall(stall), .o_ready(mrdy));
  // ----------------------------------
  // Helpers
  // ----------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [2:0] gx(input logic [3:0] g, input logic e);
    logic v;
    v = (g[1] | g[2]) ? (g[2] ? g[3] : g[0]) : e;
    return {~(g[1] | g[2]), v, v};
  endfunction
  task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic acc(input logic [1:0] sp, input logic wr, dm, input logic [2:0] ws, input logic [3:0] s);
    int n;
    logic [6:0] lo;
    n = 0;
    lo = 7'h7F;
    stall = s;
    while (o_req_ready !== 1'b1 && n < 50)
    begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    i_req = '{1'b1, ebc_space_e'(sp), wr, dm, ws};
    @(posedge i_sys_clk);
    #1 i_req.valid = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 60)
    begin
      lo = lo & o_pins;
      @(posedge i_sys_clk);
      #1 n++;
    end
    lo = lo & o_pins;
    if (n >= 60)
    begin
      error_cnt++;
      give_verdict();
    end
    chk("sels", {2'h0, lo[6:4], lo[1]}, {2'h0, sp != 2'h0, sp != 2'h1, sp != 2'h2, !wr});
    chk("strobes", {6'h0, lo[3:2]}, {6'h0, sp == 2'h2, !(sp == 2'h2 && !dm)});
    chk("lat", {7'h0, n <= (ws < EBC_READY_MIN_WS ? ws + 5 : ws + s + 8) && (ws < 2 || n > s)}, 8'h01);
    @(posedge i_sys_clk);
    #1 chk("idle", {3'h0, o_pins[6:2]}, 8'h1F);
  endtask
  // ----------------------------------
  // Sequence
  // ----------------------------------
  initial
  begin
    repeat (6) @(posedge i_sys_clk);
    #1 i_sys_rst = 1'b0;
    acc(2'h0, 1'b0, 1'b0, 3'h0, 4'hF);
    acc(2'h1, 1'b1, 1'b0, 3'h2, 4'h9);
    acc(2'h2, 1'b1, 1'b1, 3'h1, 4'hF);
    repeat (40)
    begin
      seed = xs(seed);
      acc(seed[1:0] == 2'h3 ? 2'h2 : seed[1:0], seed[2], seed[3], seed[6:4], seed[10:7]);
    end
    i_output_off_n = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1 chk("oe", {1'b0, o_pins_oe}, {1'b0, EBC_OE_ALL_OFF});
    i_output_off_n = 1'b1;
    i_interface_mode_select = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1 i_req.valid = 1'b1;
    repeat (6)
    begin
      seed = xs(seed);
      gp = seed[7:0];
      i_host_port_ready = seed[8];
      ext = ebc_pins_s'(seed[15:9]);
      repeat (5) @(posedge i_sys_clk);
      #1 chk("rdy", {7'h0, o_req_ready}, 8'h00);
      chk("hs", {5'h0, o_host_data_strobe_1_n, o_host_data_strobe_2_n, o_host_rd_wr_n},
        {5'h0, ext.prog_sel_n, ext.data_sel_n, ext.rd_wr_n});
      chk("hrdy", {6'h0, o_pins_oe.ready, i_pins.ready}, {7'h0, seed[8]});
      chk("ga", {5'h0, o_pins_oe.io_strobe_n, i_pins.io_strobe_n, o_subsys_a_gpio_line3_in},
        {5'h0, gx(gp[3:0], ext.io_strobe_n)});
      chk("gb", {5'h0, o_pins_oe.io_sel_n, i_pins.io_sel_n, o_subsys_b_gpio_line3_in},
        {5'h0, gx(gp[7:4], ext.io_sel_n)});
    end
    give_verdict();
  end
endmodule
